// ===== verilog/adc_link_pkg.sv
// Shared constants for the converter serial port and its host end.
// Assumes one 250 MHz system clock on both ends; link pins are sampled on it.
package adc_link_pkg;
  // Interface mode strap values
  typedef enum logic [1:0] {
    mode_async_irq,
    mode_sync_master,
    mode_sync_slave
  } link_mode_e;
  // Strap encoding of the three-level strap pin
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_LOW = 2'h0;
  // Word and frame limits
  localparam int WORD_W_MAX = 32;
  localparam int WORDS_MAX = 8;
  localparam int FRAME_BITS_MAX = WORD_W_MAX * WORDS_MAX;
  localparam int CNT_W = $clog2(FRAME_BITS_MAX + 1);
  // Modulator clock period and the half-period missed-result pulse
  localparam int CLK_MHZ = 250;
  localparam int MODULATOR_CLOCK_PERIOD_NS = 40;
  localparam int MODULATOR_CLOCK_PERIOD_CYC = MODULATOR_CLOCK_PERIOD_NS * CLK_MHZ / 1000;
  localparam int MISS_PULSE_CYC = (MODULATOR_CLOCK_PERIOD_CYC / 2 < 1) ? 1 : MODULATOR_CLOCK_PERIOD_CYC / 2;
  // Default divider for the internal clock; the half period is the divider value plus one system cycles
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h02;
endpackage : adc_link_pkg

// ===== verilog/adc_link_if.sv
// Serial link between the converter port and the host serial port.
// Resolves three-state data and the shared clock pin from the enables.
interface adc_link_if;
  logic cs_n;
  logic sclk_host;
  logic sclk_dev;
  logic sclk_dev_oe;
  logic din;
  logic dout_dev;
  logic dout_oe;
  logic conversion_ready_n;
  wire sclk;
  wire dout;
  // Device drives the clock only in master mode
  assign sclk = sclk_dev_oe ? sclk_dev : sclk_host;
  // Undriven data output idles high, as with a pull-up
  assign dout = dout_oe ? dout_dev : 1'b1;
  modport device (
    input cs_n, sclk_host, din,
    output sclk_dev, sclk_dev_oe, dout_dev, dout_oe, conversion_ready_n
  );
  modport host (
    output cs_n, sclk_host, din,
    input sclk, dout, conversion_ready_n
  );
endinterface : adc_link_if

// ===== verilog/adc_serial_port.sv
// Converter end of the serial link: shifts results out, commands in.
// Assumes link pins synchronous to clock; result_valid is a one-cycle pulse.
// Operation
// - Only SPI mode one, CPOL0 CPHA1.
// - Strap sampled once after reset picks mode.
// - Host holds chip select low whole frame.
// - Chip select high resets frame, tristates output.
// - Host clock idles low, bursts allowed.
// - Input data sampled on falling clock edge.
// - Command applies only after whole frame.
// - Output data changes on rising clock edge.
// - Output released after last bit shifted.
// - Ready falls every new result, ignoring select.
// - Ready stays low until select rises.
// - Overrun: half-period high pulse, flag, keep data.
// - Ready pin always driven in async mode.
// - Master drives clock, ready, data; host din.
// - Master clock runs continuously from divider.
// - Ready falling loads shifter, opens frame.
// - Master mode: both data change rising.
// - Master: ready rises after last bit.
// - Internal clock fast enough for frame.
module adc_serial_port
  import adc_link_pkg::*;
#(
  parameter int WORD_W = 24,
  parameter int WORDS = 6
) (
  // System
  input wire logic clock,
  input wire logic rstn,
  // Strap, high/low/float encoded
  input wire logic [1:0] interface_mode_strap,
  // Frame shape
  input wire logic [5:0] word_bits,
  input wire logic [3:0] words_per_frame,
  // Internal clock divider
  input wire logic [DIV_W-1:0] clock_divider_register,
  // Result source
  input wire logic result_valid,
  input wire logic [WORD_W*WORDS-1:0] result_data,
  // Received frame
  output logic rx_valid,
  output logic [WORD_W*WORDS-1:0] rx_data,
  output logic missed_result_flag,
  input wire logic missed_clear,
  output link_mode_e link_mode,
  // Link
  adc_link_if.device link
);
  localparam int FW = WORD_W * WORDS;

  typedef struct packed {
    link_mode_e mode;
    logic strap_done;
    logic sclk_prev;
    logic sclk_out;
    logic [DIV_W-1:0] div_cnt;
    logic [FW-1:0] tx;
    logic [FW-1:0] rx;
    logic [CNT_W-1:0] bits;
    logic active;
    logic launched; // First rise of the frame seen
    logic out_en;
    logic ready_n;
    logic [7:0] miss_cnt;
    logic missed;
    logic rx_valid;
    logic [FW-1:0] rx_out;
  } state_s;

  state_s s_q, s_d;
  logic master;
  logic sclk_in;
  logic rise;
  logic fall;
  logic [CNT_W-1:0] frame_bits;
  logic frame_open;
  logic overrun;

  // Frame length from configured word size and count
  // Operands widened first: the narrow product would wrap before the cast
  assign frame_bits = CNT_W'(word_bits) * CNT_W'(words_per_frame);
  assign master = (s_q.mode == mode_sync_master);
  assign sclk_in = master ? s_q.sclk_out : link.sclk_host;
  // Edges are seen one system cycle after the pin moves
  assign rise = sclk_in & ~s_q.sclk_prev;
  assign fall = ~sclk_in & s_q.sclk_prev;
  // In master mode there is no select; the frame is bounded by ready
  assign frame_open = master ? ~s_q.ready_n : ~link.cs_n;
  // A result landing inside an unfinished frame is lost, not loaded
  assign overrun = s_q.active && (s_q.bits < frame_bits);

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    // Strap caught once on the first clock after reset
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      if (interface_mode_strap == STRAP_HIGH) begin
        s_d.mode = mode_async_irq;
      end else if (interface_mode_strap == STRAP_LOW) begin
        s_d.mode = mode_sync_master;
      end else begin
        s_d.mode = mode_sync_slave;
      end
    end
    // Continuous master clock from the divider
    if (s_q.div_cnt >= clock_divider_register) begin
      s_d.div_cnt = '0;
      s_d.sclk_out = ~s_q.sclk_out;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 1'b1;
    end
    s_d.sclk_prev = sclk_in;
    // Overrun pulse countdown; ready drops back low when it expires
    if (s_q.miss_cnt != 8'h00) begin
      s_d.miss_cnt = s_q.miss_cnt - 8'h01;
      if (s_q.miss_cnt == 8'h01) begin
        s_d.ready_n = 1'b0;
      end
    end
    // Clear first, so an overrun in the same cycle still sets the flag
    if (missed_clear) begin
      s_d.missed = 1'b0;
    end
    if (!frame_open && !master) begin
      // Select high: drop any partial frame
      s_d.active = 1'b0;
      s_d.out_en = 1'b0;
      s_d.bits = '0;
      s_d.launched = 1'b0;
      if (s_q.active || s_q.bits != '0) begin
        s_d.ready_n = 1'b1;
      end
      if (s_q.bits == frame_bits && s_q.bits != '0) begin
        s_d.rx_valid = 1'b1;
        s_d.rx_out = s_q.rx;
      end
    end else if (frame_open) begin
      if (!s_q.active) begin
        s_d.active = 1'b1;
        s_d.out_en = 1'b1;
      end
      // Mode 1: launch on rise, capture on fall
      // The first rise launches the MSB already on the pin; only later rises shift
      if (rise && s_q.bits < frame_bits) begin
        if (s_q.bits != '0) begin
          s_d.tx = {s_q.tx[FW-2:0], 1'b0};
        end
        s_d.launched = 1'b1;
        s_d.out_en = 1'b1;
      end
      // A fall before the first rise belongs to no bit of this frame
      if (fall && s_q.active && s_q.launched && s_q.bits < frame_bits) begin
        s_d.rx = {s_q.rx[FW-2:0], link.din};
        s_d.bits = s_q.bits + 1'b1;
        if (s_q.bits + 1'b1 == frame_bits) begin
          s_d.out_en = 1'b0;
          if (master) begin
            s_d.ready_n = 1'b1;
            s_d.active = 1'b0;
            s_d.bits = '0;
            s_d.launched = 1'b0;
            s_d.rx_valid = 1'b1;
            s_d.rx_out = {s_q.rx[FW-2:0], link.din};
          end
        end
      end
    end
    // New result: load, or flag an overrun and keep the shifter
    // A loaded result that was never read is simply replaced by the newer one
    if (result_valid && s_q.strap_done) begin
      if (overrun) begin
        s_d.missed = 1'b1;
        s_d.ready_n = 1'b1;
        s_d.miss_cnt = 8'(MISS_PULSE_CYC);
      end else begin
        s_d.tx = result_data;
        s_d.launched = 1'b0;
        s_d.ready_n = 1'b0;
        s_d.bits = '0;
        s_d.active = 1'b0;
      end
    end
  end

  // Single state register
  // Reset is synchronous, so the strap is taken on the first edge after release
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '{mode: mode_async_irq, ready_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Pins: ready always driven in async mode, clock only in master mode
  // Data enable needs the count short of the frame, so the pin frees at the last bit
  assign link.conversion_ready_n = s_q.ready_n;
  assign link.sclk_dev = s_q.sclk_out;
  assign link.sclk_dev_oe = master & s_q.strap_done;
  assign link.dout_dev = s_q.tx[FW-1];
  assign link.dout_oe = s_q.out_en & frame_open & (s_q.bits < frame_bits);
  assign rx_valid = s_q.rx_valid;
  assign rx_data = s_q.rx_out;
  assign missed_result_flag = s_q.missed;
  assign link_mode = s_q.mode;
endmodule : adc_serial_port

// ===== verilog/adc_host_port.sv
// Host end of the serial link: frames a readback with select and clock.
// Assumes pins synchronous to clock; in master mode it follows device clock.
module adc_host_port
  import adc_link_pkg::*;
#(
  parameter int FW = 144,
  parameter int HALF = 4
) (
  // System
  input wire logic clock,
  input wire logic rstn,
  // User side
  input wire logic master_mode,
  input wire logic [CNT_W-1:0] frame_bits,
  input wire logic [FW-1:0] cmd_data,
  output logic frame_done,
  output logic [FW-1:0] read_data,
  // Link
  adc_link_if.host link
);
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [7:0] div;
    logic [CNT_W-1:0] bits;
    logic [FW-1:0] tx;
    logic [FW-1:0] rx;
    logic rdy_prev;
    logic sclk_prev;
    logic launched;
    logic done;
  } state_s;
  state_s s_q, s_d;

  // Async mode: select low for whole frame, clock idles low
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rdy_prev = link.conversion_ready_n;
    s_d.sclk_prev = link.sclk;
    if (master_mode) begin
      // First rise in the frame launches the MSB; later rises shift
      if (link.sclk && !s_q.sclk_prev && !link.conversion_ready_n) begin
        if (s_q.bits != '0) begin
          s_d.tx = {s_q.tx[FW-2:0], 1'b0};
        end
        s_d.launched = 1'b1;
      end
      if (!link.sclk && s_q.sclk_prev && !link.conversion_ready_n && s_q.launched) begin
        s_d.rx = {s_q.rx[FW-2:0], link.dout};
        s_d.bits = s_q.bits + 1'b1;
        if (s_q.bits + 1'b1 == frame_bits) begin
          s_d.done = 1'b1;
          s_d.launched = 1'b0;
        end
      end
      // Ready fall opens the frame; a rise on that same edge is the launch
      if (s_q.rdy_prev && !link.conversion_ready_n) begin
        s_d.tx = cmd_data;
        s_d.bits = '0;
        s_d.launched = link.sclk & ~s_q.sclk_prev;
      end
    end else if (s_q.cs_n) begin
      if (s_q.rdy_prev && !link.conversion_ready_n) begin
        s_d.cs_n = 1'b0;
        s_d.tx = cmd_data;
        s_d.bits = '0;
        s_d.div = '0;
      end
    end else if (s_q.div == 8'(HALF - 1)) begin
      s_d.div = '0;
      if (s_q.bits == frame_bits && !s_q.sclk) begin
        s_d.cs_n = 1'b1;
        s_d.done = 1'b1;
      end else if (!s_q.sclk) begin
        s_d.sclk = 1'b1;
        if (s_q.bits != '0) begin
          s_d.tx = {s_q.tx[FW-2:0], 1'b0};
        end
      end else begin
        s_d.sclk = 1'b0;
        s_d.rx = {s_q.rx[FW-2:0], link.dout};
        s_d.bits = s_q.bits + 1'b1;
      end
    end else begin
      s_d.div = s_q.div + 8'h01;
    end
  end

  // Single state register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '{cs_n: 1'b1, rdy_prev: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign link.cs_n = s_q.cs_n;
  assign link.sclk_host = s_q.sclk;
  assign link.din = s_q.tx[FW-1];
  assign frame_done = s_q.done;
  assign read_data = s_q.rx;
endmodule : adc_host_port

// ===== test/adc_link_checker.sv
// Checker on the link wires between converter port and host port.
// Assumes divider 2 (3-cycle master half period) and FB-bit frames.
module adc_link_checker #(
  parameter int FB = 144
) (
  // System
  input wire logic clock,
  input wire logic rstn,
  // Link
  input wire logic cs_n,
  input wire logic sclk_host,
  input wire logic sclk_dev,
  input wire logic sclk_dev_oe,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_dev,
  input wire logic dout_oe,
  input wire logic conversion_ready_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  logic [11:0] low_q;
  // Ready low time in master mode; a stuck frame shows up here
  always_ff @(posedge clock)
    low_q <= (!rstn || conversion_ready_n || !sclk_dev_oe) ? 12'h000 : low_q + 12'h001;
  chk_cs_tristate: assert property ((cs_n && !sclk_dev_oe)[*3] |-> !dout_oe)
    else $error("data driven while deselected");
  chk_dout_rise: assert property ($changed(dout_dev) && dout_oe && $past(dout_oe) |-> sclk)
    else $error("data out moved with clock low");
  chk_din_rise: assert property ($changed(din) && !cs_n && $past(!cs_n) |-> sclk)
    else $error("data in moved with clock low");
  chk_sclk_idle: assert property (cs_n && !sclk_dev_oe |-> !sclk_host)
    else $error("host clock high while idle");
  chk_ready_release: assert property ($rose(cs_n) && !sclk_dev_oe |-> ##[0:2] conversion_ready_n)
    else $error("ready stayed low after deselect");
  chk_miss_pulse: assert property ($rose(conversion_ready_n) && !cs_n && !sclk_dev_oe
    |-> conversion_ready_n[*5] ##1 !conversion_ready_n)
    else $error("overrun pulse width wrong");
  chk_master_clk: assert property (sclk_dev_oe && $rose(sclk_dev) |-> sclk_dev[*3] ##1 !sclk_dev)
    else $error("master clock half period wrong");
  chk_master_frame: assert property (int'(low_q) <= FB * 6 + 16)
    else $error("master frame too long");
  chk_master_end: assert property ($fell(dout_oe) && sclk_dev_oe |-> ##[0:8] conversion_ready_n)
    else $error("ready not back after last bit");
endmodule : adc_link_checker

// ===== test/tb_top.sv
// Bench joining converter port and host port over one link.
// Assumes 144-bit frames, host half clock 4, divider 2.
module tb_top
  import adc_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] strap = 2'h1;
  logic rv = 1'b0;
  logic [143:0] rd = '0;
  logic mclr = 1'b0;
  logic mm = 1'b0;
  logic [143:0] cmd = {9{16'h5AC3}};
  logic rx_valid, frame_done, missed, fd_seen, rv_seen;
  logic [143:0] rx_data, read_data;
  link_mode_e mode;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  // Clock at 250 MHz
  always #2 clock = ~clock;
  adc_link_if link ();
  adc_serial_port u_adc_serial_port (.clock(clock), .rstn(rstn), .interface_mode_strap(strap),
    .word_bits(6'h18), .words_per_frame(4'h6), .clock_divider_register(DIV_RESET),
    .result_valid(rv), .result_data(rd), .rx_valid(rx_valid), .rx_data(rx_data),
    .missed_result_flag(missed), .missed_clear(mclr), .link_mode(mode), .link(link));
  adc_host_port u_adc_host_port (.clock(clock), .rstn(rstn), .master_mode(mm),
    .frame_bits(CNT_W'(9'h090)), .cmd_data(cmd), .frame_done(frame_done),
    .read_data(read_data), .link(link));
  adc_link_checker u_adc_link_checker (.clock(clock), .rstn(rstn), .cs_n(link.cs_n),
    .sclk_host(link.sclk_host), .sclk_dev(link.sclk_dev), .sclk_dev_oe(link.sclk_dev_oe),
    .sclk(link.sclk), .din(link.din), .dout_dev(link.dout_dev), .dout_oe(link.dout_oe),
    .conversion_ready_n(link.conversion_ready_n));
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_vec(input logic [143:0] got, input logic [143:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp_vec
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_vec({143'h0, got}, {143'h0, exp});
  endtask : cmp_bit
  // Reset with a new strap; strap is taken on the first edge after release
  task automatic restart(input logic [1:0] s, input logic m);
    strap <= s;
    mm <= m;
    rstn <= 1'b0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : restart
  task automatic push(input logic [143:0] d);
    @(posedge clock);
    fd_seen = 1'b0;
    rv_seen = 1'b0;
    rd <= d;
    rv <= 1'b1;
    @(posedge clock);
    rv <= 1'b0;
  endtask : push
  // Wait for both ends to close the frame, bounded
  task automatic finish_frame();
    int n;
    n = 0;
    while (!(fd_seen && rv_seen) && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (n == 3000)
      errors++;
    repeat (4) @(posedge clock);
    #1;
  endtask : finish_frame
  // Latch one-cycle pulses and cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (frame_done === 1'b1)
      fd_seen = 1'b1;
    if (rx_valid === 1'b1)
      rv_seen = 1'b1;
    if (cyc == 12000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    restart(2'h1, 1'b0);
    #1;
    cmp_vec({142'h0, mode}, {142'h0, mode_async_irq});
    cmp_bit(link.conversion_ready_n, 1'b1);
    push({9{16'hA5C3}});
    repeat (2) @(posedge clock);
    #1;
    cmp_bit(link.conversion_ready_n, 1'b0);
    finish_frame();
    cmp_vec(read_data, {9{16'hA5C3}});
    cmp_vec(rx_data, {9{16'h5AC3}});
    cmp_bit(link.conversion_ready_n, 1'b1);
    cmp_bit(link.dout_oe, 1'b0);
    cmp_bit(missed, 1'b0);
    // Next result is read; a later one lands mid-frame and is dropped
    push({9{16'h3C5A}});
    repeat (200) @(posedge clock);
    cmp_bit(rv_seen, 1'b0);
    push({18{8'h96}});
    finish_frame();
    cmp_vec(read_data, {9{16'h3C5A}});
    cmp_bit(missed, 1'b1);
    @(posedge clock);
    mclr <= 1'b1;
    @(posedge clock);
    mclr <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    cmp_bit(missed, 1'b0);
    @(posedge clock);
    cmd <= {9{16'h0FF1}};
    restart(2'h0, 1'b1);
    #1;
    cmp_vec({142'h0, mode}, {142'h0, mode_sync_master});
    push({9{16'hE718}});
    finish_frame();
    cmp_vec(read_data, {9{16'hE718}});
    cmp_vec(rx_data, {9{16'h0FF1}});
    cmp_bit(link.conversion_ready_n, 1'b1);
    // Floating strap: slave mode, link stays quiet while deselected
    @(posedge clock);
    restart(2'h2, 1'b0);
    #1;
    cmp_vec({142'h0, mode}, {142'h0, mode_sync_slave});
    cmp_bit(link.dout_oe, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
